// *** cas_pkg.sv ***
// Purpose: constants for the card address and status register group
// Assumes: commands arrive already decoded on the link clock
// Notes: addresses travel in the upper half of the command argument
//
// What this block does
// - holds a writable 16-bit relative card address set by the host
// - after identification, answers addressed commands only on address match
// - relative card address resets to 0x0001
// - address 0x0000 is reserved; select with it puts card in standby
// - optional 16-bit driver stage register tunes bus driving
// - card-specific data reports whether driver stage register exists
// - driver stage register resets to 0x404
// - status register shows current state and last completion code
// - host polls status outside identification; reply carries current status contents
package cas_pkg;
    localparam logic [5:0] CAS_CMD_GO_IDLE = 6'h00;
    localparam logic [5:0] CAS_CMD_SET_ADDR = 6'h03;
    localparam logic [5:0] CAS_CMD_SET_DSR = 6'h04;
    localparam logic [5:0] CAS_CMD_SELECT = 6'h07;
    localparam logic [5:0] CAS_CMD_SEND_STATUS = 6'h0d;
    localparam logic [15:0] CAS_RCA_RESET = 16'h0001;
    localparam logic [15:0] CAS_RCA_RESERVED = 16'h0000;
    localparam logic [15:0] CAS_DSR_RESET = 16'h0404;
    localparam int CAS_ARG_ADDR_LSB = 16;
    localparam int CAS_STAT_STATE_LSB = 9;
    localparam int CAS_STAT_STATE_W = 4;
    localparam logic [3:0] CAS_CODE_IDENT = 4'h2;
    localparam logic [3:0] CAS_CODE_STBY = 4'h3;
    localparam logic [3:0] CAS_CODE_TRAN = 4'h4;

    typedef enum logic [2:0] {
        CAS_ST_IDENT = 3'b001,
        CAS_ST_STBY = 3'b010,
        CAS_ST_TRAN = 3'b100
    } cas_state_t;
endpackage : cas_pkg

// *** cas_regs.sv ***
// Purpose: relative address, driver stage and status registers of a card
// Assumes: decoded commands and responses are on the link clock
// Notes: status word crosses from the core clock by a toggle handshake
`timescale 1ns/1ps
module cas_regs
    import cas_pkg::*;
#(
    parameter bit DSR_IMP = 1'b1
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [31:0] status_i,
    input wire logic clk_link_i,
    input wire logic cmd_valid_i,
    input wire logic [5:0] cmd_index_i,
    input wire logic [31:0] cmd_arg_i,
    output logic resp_valid_o,
    output logic [5:0] resp_index_o,
    output logic [31:0] resp_data_o,
    output logic [15:0] rca_o,
    output logic [15:0] dsr_o,
    output logic selected_o,
    output logic csd_dsr_imp_o
);

    typedef struct packed {
        logic req;
        logic [31:0] snap;
        logic ack_s1;
        logic ack_s2;
    } cas_core_t;

    typedef struct packed {
        logic [1:0] rst_q;
        logic req_s1;
        logic req_s2;
        logic ack;
        logic [31:0] status;
        cas_state_t state;
        logic [15:0] relative_card_address;
        logic [15:0] dsr;
        logic resp_valid;
        logic [5:0] resp_index;
        logic [31:0] resp_data;
    } cas_link_t;

    cas_core_t core_r;
    cas_core_t core_nxt;
    cas_link_t link_r;
    cas_link_t link_nxt;
    logic link_rst_n;
    logic [15:0] cmd_addr;

    function automatic logic [3:0] cas_code(input cas_state_t s);
        case (s)
            CAS_ST_IDENT: cas_code = CAS_CODE_IDENT;
            CAS_ST_STBY: cas_code = CAS_CODE_STBY;
            CAS_ST_TRAN: cas_code = CAS_CODE_TRAN;
            default: cas_code = CAS_CODE_IDENT;
        endcase
    endfunction : cas_code

    function automatic logic [31:0] cas_word(input logic [31:0] st,
                                             input cas_state_t s);
        logic [31:0] w;
        w = st;
        w[CAS_STAT_STATE_LSB +: CAS_STAT_STATE_W] = cas_code(s);
        cas_word = w;
    endfunction : cas_word

    // core domain: publish status snapshot
    always_comb begin
        core_nxt = core_r;
        core_nxt.ack_s1 = link_r.ack;
        core_nxt.ack_s2 = core_r.ack_s1;
        if (core_r.ack_s2 == core_r.req) begin
            core_nxt.snap = status_i;
            core_nxt.req = ~core_r.req;
        end
        if (!rst_n_i) begin
            core_nxt = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        core_r <= core_nxt;
    end

    assign link_rst_n = link_r.rst_q[1];
    assign cmd_addr = cmd_arg_i[CAS_ARG_ADDR_LSB +: 16];

    // link domain: command handling
    always_comb begin
        link_nxt = link_r;
        link_nxt.rst_q = {link_r.rst_q[0], rst_n_i};
        link_nxt.req_s1 = core_r.req;
        link_nxt.req_s2 = link_r.req_s1;
        link_nxt.resp_valid = 1'b0;
        if (link_r.req_s2 != link_r.ack) begin
            link_nxt.status = core_r.snap;
            link_nxt.ack = link_r.req_s2;
        end
        if (cmd_valid_i) begin
            case (cmd_index_i)
                CAS_CMD_GO_IDLE: begin
                    link_nxt.state = CAS_ST_IDENT;
                end
                CAS_CMD_SET_ADDR: begin
                    if (link_r.state == CAS_ST_IDENT &&
                        cmd_addr != CAS_RCA_RESERVED) begin
                        link_nxt.relative_card_address = cmd_addr;
                        link_nxt.state = CAS_ST_STBY;
                        link_nxt.resp_valid = 1'b1;
                        link_nxt.resp_index = cmd_index_i;
                        link_nxt.resp_data = cas_word(link_r.status,
                                                      link_r.state);
                    end
                end
                CAS_CMD_SET_DSR: begin
                    if (DSR_IMP && link_r.state == CAS_ST_STBY) begin
                        link_nxt.dsr = cmd_addr;
                    end
                end
                CAS_CMD_SELECT: begin
                    if (link_r.state != CAS_ST_IDENT) begin
                        if (cmd_addr == link_r.relative_card_address) begin
                            link_nxt.state = CAS_ST_TRAN;
                            link_nxt.resp_valid = 1'b1;
                            link_nxt.resp_index = cmd_index_i;
                            link_nxt.resp_data = cas_word(link_r.status,
                                                          link_r.state);
                        end else begin
                            link_nxt.state = CAS_ST_STBY;
                        end
                    end
                end
                CAS_CMD_SEND_STATUS: begin
                    if (link_r.state != CAS_ST_IDENT &&
                        cmd_addr == link_r.relative_card_address) begin
                        link_nxt.resp_valid = 1'b1;
                        link_nxt.resp_index = cmd_index_i;
                        link_nxt.resp_data = cas_word(link_r.status,
                                                      link_r.state);
                    end
                end
                default: begin
                    link_nxt.resp_valid = 1'b0;
                end
            endcase
        end
        if (!link_rst_n) begin
            link_nxt.req_s1 = 1'b0;
            link_nxt.req_s2 = 1'b0;
            link_nxt.ack = 1'b0;
            link_nxt.status = '0;
            link_nxt.state = CAS_ST_IDENT;
            link_nxt.relative_card_address = CAS_RCA_RESET;
            link_nxt.dsr = CAS_DSR_RESET;
            link_nxt.resp_valid = 1'b0;
            link_nxt.resp_index = '0;
            link_nxt.resp_data = '0;
        end
    end

    always_ff @(posedge clk_link_i) begin
        link_r <= link_nxt;
    end

    assign resp_valid_o = link_r.resp_valid;
    assign resp_index_o = link_r.resp_index;
    assign resp_data_o = link_r.resp_data;
    assign rca_o = link_r.relative_card_address;
    assign dsr_o = link_r.dsr;
    assign selected_o = (link_r.state == CAS_ST_TRAN);
    assign csd_dsr_imp_o = DSR_IMP;

    // checks
    sequence seq_set_addr;
        cmd_valid_i && cmd_index_i == CAS_CMD_SET_ADDR &&
            link_r.state == CAS_ST_IDENT && cmd_addr != CAS_RCA_RESERVED;
    endsequence

    sequence seq_status_poll;
        cmd_valid_i && cmd_index_i == CAS_CMD_SEND_STATUS &&
            link_r.state != CAS_ST_IDENT && cmd_addr == link_r.relative_card_address;
    endsequence

    chk_rca_reset: assert property (
        @(posedge clk_link_i) !link_rst_n |=> rca_o == CAS_RCA_RESET)
        else $error("relative address not at default after reset");

    chk_dsr_reset: assert property (
        @(posedge clk_link_i) !link_rst_n |=> dsr_o == CAS_DSR_RESET)
        else $error("driver stage not at default after reset");

    chk_rca_load: assert property (
        @(posedge clk_link_i) disable iff (!link_rst_n)
        seq_set_addr |=> rca_o == $past(cmd_addr) && resp_valid_o)
        else $error("relative address not loaded");

    chk_rca_nonzero: assert property (
        @(posedge clk_link_i) disable iff (!link_rst_n)
        rca_o != CAS_RCA_RESERVED)
        else $error("reserved address assigned");

    chk_zero_standby: assert property (
        @(posedge clk_link_i) disable iff (!link_rst_n)
        cmd_valid_i && cmd_index_i == CAS_CMD_SELECT &&
            cmd_addr == CAS_RCA_RESERVED && link_r.state != CAS_ST_IDENT
        |=> link_r.state == CAS_ST_STBY && !selected_o && !resp_valid_o)
        else $error("select with zero did not give standby");

    chk_addr_mismatch: assert property (
        @(posedge clk_link_i) disable iff (!link_rst_n)
        cmd_valid_i && cmd_index_i == CAS_CMD_SEND_STATUS &&
            cmd_addr != rca_o |=> !resp_valid_o)
        else $error("answered a command for another address");

    chk_status_reply: assert property (
        @(posedge clk_link_i) disable iff (!link_rst_n)
        seq_status_poll |=> resp_valid_o &&
            resp_index_o == CAS_CMD_SEND_STATUS &&
            resp_data_o == cas_word($past(link_r.status),
                                    $past(link_r.state)))
        else $error("status reply wrong");

    chk_rca_hold: assert property (
        @(posedge clk_link_i) disable iff (!link_rst_n || !$past(link_rst_n))
        !$past(cmd_valid_i && cmd_index_i == CAS_CMD_SET_ADDR)
        |-> $stable(rca_o))
        else $error("relative address changed without assignment");

    chk_dsr_absent: assert property (
        @(posedge clk_link_i) disable iff (!link_rst_n)
        !csd_dsr_imp_o |-> dsr_o == CAS_DSR_RESET)
        else $error("absent driver stage register was written");

    chk_snap_stable: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        core_r.ack_s2 != core_r.req |=> $stable(core_r.snap))
        else $error("status snapshot moved during crossing");

endmodule : cas_regs

// *** cas_host_model.sv ***
// Purpose: host model issuing decoded commands on the link clock
// Assumes: the card samples commands on the rising link edge
// Notes: idle fields carry the inverse of the last value
`timescale 1ns/1ps
module cas_host_model (
    input wire logic clk_link_i,
    output logic cmd_valid_o,
    output logic [5:0] cmd_index_o,
    output logic [31:0] cmd_arg_o
);
    initial begin
        cmd_valid_o = 1'b0;
        cmd_index_o = 6'h3f;
        cmd_arg_o = 32'hffffffff;
    end
    // drives any command for one link cycle, address held in arg upper half
    task automatic send(input logic [5:0] idx, input logic [31:0] arg);
        @(posedge clk_link_i);
        cmd_valid_o <= 1'b1;
        cmd_index_o <= idx;
        cmd_arg_o <= arg;
        @(posedge clk_link_i);
        cmd_valid_o <= 1'b0;
        cmd_index_o <= ~idx;
        cmd_arg_o <= ~arg;
        #1;
    endtask : send
endmodule : cas_host_model

// *** card_address_status_regs_tb.sv ***
// Purpose: self-checking bench for the address and status registers
// Assumes: reply state field is the state before the command
// Notes: integer model predicts every reply and register value
`timescale 1ns/1ps
module card_address_status_regs_tb;
    import cas_pkg::*;
    logic clk_i = 1'b0, clk_link_i = 1'b0, rst_n_i = 1'b0;
    logic [31:0] status_i = 32'h0;
    logic cmd_valid, resp_valid_o, selected_o, csd_dsr_imp_o;
    logic [5:0] cmd_index, resp_index_o;
    logic [31:0] cmd_arg, resp_data_o;
    logic [15:0] rca_o, dsr_o, a, m_rca, m_dsr;
    int err_count = 0, tests_run = 0, cycles = 0, m_state;
    always #4 clk_i = ~clk_i;
    always #6 clk_link_i = ~clk_link_i;
    cas_host_model host (.clk_link_i(clk_link_i), .cmd_valid_o(cmd_valid),
        .cmd_index_o(cmd_index), .cmd_arg_o(cmd_arg));
    cas_regs uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .status_i(status_i),
        .clk_link_i(clk_link_i), .cmd_valid_i(cmd_valid),
        .cmd_index_i(cmd_index), .cmd_arg_i(cmd_arg),
        .resp_valid_o(resp_valid_o), .resp_index_o(resp_index_o),
        .resp_data_o(resp_data_o), .rca_o(rca_o), .dsr_o(dsr_o),
        .selected_o(selected_o), .csd_dsr_imp_o(csd_dsr_imp_o));
    task automatic end_sim;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            end_sim();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic do_reset;
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'b1;
        m_state = 2;
        m_rca = CAS_RCA_RESET;
        m_dsr = CAS_DSR_RESET;
        repeat (10) @(posedge clk_link_i);
        #1;
        chk("rca_o", 32'h0001, 32'(rca_o));
        chk("dsr_o", 32'h0404, 32'(dsr_o));
    endtask : do_reset
    task automatic cmd(input logic [5:0] idx, input logic [15:0] ad);
        logic ans;
        logic [31:0] e;
        ans = 1'b0;
        e = status_i;
        e[12:9] = 4'(m_state);
        case (idx)
            CAS_CMD_SET_ADDR: if (m_state == 2 && ad != 16'h0) begin
                ans = 1'b1;
                m_rca = ad;
                m_state = 3;
            end
            CAS_CMD_SET_DSR: if (m_state == 3) m_dsr = ad;
            CAS_CMD_SELECT: if (m_state != 2) begin
                ans = (ad == m_rca);
                m_state = ans ? 4 : 3;
            end
            CAS_CMD_SEND_STATUS: ans = (m_state != 2 && ad == m_rca);
            CAS_CMD_GO_IDLE: m_state = 2;
            default: ans = 1'b0;
        endcase
        host.send(idx, {ad, 16'($urandom)});
        chk("resp_valid", 32'(ans), 32'(resp_valid_o));
        if (ans) begin
            chk("resp_index", 32'(idx), 32'(resp_index_o));
            chk("resp_data", e, resp_data_o);
        end
        chk("rca_o", 32'(m_rca), 32'(rca_o));
        chk("dsr_o", 32'(m_dsr), 32'(dsr_o));
        chk("selected", 32'(m_state == 4), 32'(selected_o));
    endtask : cmd
    initial begin
        void'($urandom(32'h2a25092e));
        status_i = $urandom;
        do_reset();
        chk("dsr_imp", 32'h1, 32'(csd_dsr_imp_o));
        $display("test reset values done");
        cmd(CAS_CMD_SEND_STATUS, 16'h0001);
        cmd(CAS_CMD_SELECT, 16'h0001);
        cmd(CAS_CMD_SET_ADDR, CAS_RCA_RESERVED);
        cmd(CAS_CMD_SET_DSR, 16'h1234);
        $display("test identification refusals done");
        a = 16'($urandom_range(16'hffff, 1));
        cmd(CAS_CMD_SET_ADDR, a);
        cmd(CAS_CMD_SEND_STATUS, a ^ 16'h0001);
        @(posedge clk_i);
        status_i <= $urandom;
        repeat (10) @(posedge clk_link_i);
        cmd(CAS_CMD_SEND_STATUS, a);
        if (csd_dsr_imp_o === 1'b1) cmd(CAS_CMD_SET_DSR, 16'($urandom));
        $display("test address assignment done");
        cmd(CAS_CMD_SELECT, a);
        cmd(CAS_CMD_SEND_STATUS, a);
        cmd(CAS_CMD_SET_DSR, 16'h5555);
        cmd(CAS_CMD_SET_ADDR, 16'h0077);
        cmd(CAS_CMD_SELECT, CAS_RCA_RESERVED);
        cmd(CAS_CMD_SEND_STATUS, a);
        $display("test select and standby done");
        cmd(CAS_CMD_GO_IDLE, a);
        cmd(CAS_CMD_SEND_STATUS, a);
        do_reset();
        cmd(CAS_CMD_SET_ADDR, 16'hfffe);
        $display("test idle and reset done");
        end_sim();
    end
endmodule : card_address_status_regs_tb
